// >>> testbench/lvs_host.sv
// host model: drives register writes and reads on the register port
`timescale 1ns/100ps
`default_nettype none
module lvs_host import lvs_pkg::*; (
  input wire logic core_clk,
  output lvs_reg_req_t req,
  input wire logic [15:0] reg_rdata
);
  // idle port from time zero
  initial begin
    req = '0;
  end
  // write: raised after an edge, taken at the next edge, then released
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    // released lines show the inverse, never the old value
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // read: data is settled just after the taking edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk);
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
    d = reg_rdata;
  endtask
  // mode write; callers keep the period phase among enabled phases
  task automatic set_mode(input logic [2:0] en, input logic [1:0] pk, input logic [1:0] per);
    wr(A_MODE, {9'h000, en, pk, per});
  endtask
endmodule
`default_nettype wire

// >>> testbench/lvs_supervisor_bench.sv
// self-checking bench of the line voltage supervisor
`timescale 1ns/100ps
`default_nettype none
module lvs_supervisor_bench import lvs_pkg::*;;
  logic core_clk = 1'b0; // master clock
  logic srst = 1'b1; // synchronous reset
  lvs_samples_t smp = '0; // signal chain inputs
  lvs_reg_req_t req; // register request from host
  logic [15:0] reg_rdata; // register read data
  logic irq_n; // interrupt, active low
  logic [15:0] rv; // last read value
  logic [15:0] w; // random write value
  logic [2:0][7:0] vh; // voltage high bytes
  logic [2:0][7:0] ih; // current high bytes
  int fails = 0; // mismatches
  int checked = 0; // comparisons
  int k; // period length in ticks
  int p; // phase under test
  // reset value table, last entry unmapped
  localparam logic [7:0] RA [9] = '{A_MODE, A_TOUT, A_DIP_LVL, A_DIP_CYC, A_VOLTAGE_PEAK_LEVEL, A_CURRENT_PEAK_LEVEL,
    A_MASK, A_STATUS, 8'h3F};
  localparam logic [15:0] RR [9] = '{16'(MODE_RST), TOUT_RST, 16'(DIP_LVL_RST),
    16'(DIP_CYC_RST), 16'(PEAK_RST), 16'(PEAK_RST), MASK_RST, 16'h0000, 16'h0000};
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  lvs_supervisor i_lvs_supervisor (.core_clk(core_clk), .srst(srst), .smp(smp), .req(req),
    .reg_rdata(reg_rdata), .irq_n(irq_n));
  lvs_host i_lvs_host (.core_clk(core_clk), .req(req), .reg_rdata(reg_rdata));
  // compare one value
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic end_of_test();
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // read a register and compare
  task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    i_lvs_host.rd(a, rv);
    chk(what, rv, exp);
  endtask
  // let n edges pass, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one-cycle crossing pulse
  task automatic zx(input logic [2:0] m);
    @(posedge core_clk);
    #1 smp.zx = m;
    @(posedge core_clk);
    #1 smp.zx = 3'b000;
  endtask
  // one sample strobe on all phases, random low bytes
  task automatic sample(input logic [2:0][7:0] v, input logic [2:0][7:0] c);
    @(posedge core_clk);
    #1 smp.valid = 1'b1;
    for (int i = 0; i < PH_N; i++) begin
      smp.volt[i] = {v[i], 8'($urandom)};
      smp.curr[i] = {c[i], 16'($urandom)};
    end
    @(posedge core_clk);
    #1 smp.valid = 1'b0;
  endtask
  // one half cycle of 1 to 3 samples, same level on every phase
  task automatic half(input logic neg, input logic [7:0] mag);
    logic [7:0] hb;
    hb = neg ? 8'(8'h00 - mag) : mag;
    repeat (1 + $urandom % 3) sample({3{hb}}, 24'h000000);
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    end_of_test();
  end
  // main sequence
  initial begin
    void'($urandom(49));
    repeat (10) @(posedge core_clk);
    #1 srst = 1'b0;
    // reset values and unmapped read
    for (int i = 0; i < 9; i++) rchk("reset value", RA[i], RR[i]);
    // random readback of byte registers, upper bits dropped
    for (int i = 2; i < 6; i++) begin
      w = 16'($urandom);
      i_lvs_host.wr(RA[i], w);
      rchk("readback", RA[i], {8'h00, w[7:0]});
    end
    // voltage peak level out of reach of the dip half cycles
    i_lvs_host.wr(A_VOLTAGE_PEAK_LEVEL, 16'(PEAK_RST));
    w = 16'($urandom);
    i_lvs_host.wr(A_TOUT, w);
    rchk("reload", A_TOUT, w);
    i_lvs_host.wr(A_TOUT, TOUT_RST);
    i_lvs_host.wr(A_PERIOD, 16'h1234);
    rchk("period read-only", A_PERIOD, 16'h0000);
    // crossing flags, interrupt and clear on read
    i_lvs_host.wr(A_MASK, 16'h0380);
    for (int i = 0; i < PH_N; i++) begin
      zx(3'b001 << i);
      cyc(1);
      chk("irq on crossing", {15'h0000, irq_n}, 16'h0000);
      rchk("crossing flag", A_STATUS_CLEAR_ON_READ, 16'h0080 << i);
      rchk("flag cleared", A_STATUS, 16'h0000);
      chk("irq released", {15'h0000, irq_n}, 16'h0001);
    end
    // all phases disabled, no period phase: no interrupt, missing flags read set
    i_lvs_host.set_mode(3'b000, 2'd0, 2'd3);
    zx(3'b001);
    cyc(2);
    chk("irq gated", {15'h0000, irq_n}, 16'h0001);
    rchk("disabled plain view", A_STATUS, 16'h00F0);
    rchk("disabled view", A_STATUS_CLEAR_ON_READ, 16'h00F0);
    i_lvs_host.set_mode(3'b111, 2'd0, 2'd0);
    // missing crossing after three ticks of a short reload
    p = $urandom % 3;
    i_lvs_host.wr(A_TOUT, 16'h0003);
    i_lvs_host.wr(A_MASK, 16'h0010 << p);
    zx(3'b001 << p);
    cyc(700);
    rchk("no early timeout", A_STATUS, 16'h0080 << p);
    cyc(460);
    chk("irq on timeout", {15'h0000, irq_n}, 16'h0000);
    rchk("missing flag", A_STATUS_CLEAR_ON_READ, 16'h0090 << p);
    // dips: strict level and restart of the half-cycle count
    i_lvs_host.wr(A_DIP_LVL, 16'h0020);
    i_lvs_host.wr(A_DIP_CYC, 16'h0002);
    i_lvs_host.wr(A_MASK, 16'h000E);
    half(1'b0, 8'h40);
    half(1'b1, 8'h1F);
    half(1'b0, 8'h20);
    half(1'b1, 8'h1F);
    half(1'b0, 8'h1F);
    rchk("no dip yet", A_STATUS, 16'h0000);
    half(1'b1, 8'h40);
    cyc(2);
    chk("irq on dip", {15'h0000, irq_n}, 16'h0000);
    rchk("dip flags", A_STATUS_CLEAR_ON_READ, 16'h000E);
    // peaks on one selected phase
    p = $urandom % 3;
    i_lvs_host.set_mode(3'b111, 2'(p), 2'd0);
    i_lvs_host.wr(A_VOLTAGE_PEAK_LEVEL, 16'h0030);
    i_lvs_host.wr(A_CURRENT_PEAK_LEVEL, 16'h0030);
    i_lvs_host.wr(A_MASK, 16'h0C00);
    vh = {3{8'h7F}};
    ih = {3{8'h80}};
    vh[p] = 8'hD0;
    ih[p] = 8'h30;
    sample(vh, ih);
    cyc(1);
    rchk("no peak at level", A_STATUS, 16'h0000);
    vh[p] = 8'hCF;
    ih[p] = 8'h31;
    sample(vh, ih);
    cyc(1);
    chk("irq on peak", {15'h0000, irq_n}, 16'h0000);
    rchk("peak flags", A_STATUS_CLEAR_ON_READ, 16'h0C00);
    // period of random length, crossings of other phases in between
    for (int n = 0; n < 3; n++) begin
      p = $urandom % 3;
      k = 50 + $urandom % 150;
      i_lvs_host.set_mode(3'b111, 2'd3, 2'(p));
      zx(3'b001 << p);
      zx(3'b111 & ~(3'b001 << p));
      cyc(24 * k - 4);
      zx(3'b001 << p);
      i_lvs_host.rd(A_PERIOD, rv);
      chk("period range", {15'h0000, rv >= k - 1 && rv <= k}, 16'h0001);
    end
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> verilog/lvs_phase.sv
// one phase: missing crossing timeout and voltage dip half-cycle counting
`timescale 1ns/100ps
`default_nettype none
module lvs_phase import lvs_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic tick_to,
  input wire logic smp_valid,
  input wire logic zx_pulse,
  input wire logic [7:0] v_hi,
  input wire logic [7:0] dip_level,
  input wire logic [7:0] dip_half_cycles,
  input wire logic [15:0] tout_reload,
  output logic miss_evt,
  output logic sag_evt
);
  lvs_ph_state_t q, d;   // whole state and its next value
  logic below;           // this sample under the dip level
  logic [7:0] half_inc;  // saturating next half-cycle count

  // next state
  always_comb begin
    d = q;
    d.miss_evt = 1'b0;
    d.sag_evt = 1'b0;
    below = {1'b0, dip_level} > abs_hi(v_hi);
    half_inc = (q.half_cnt == HALF_MAX) ? HALF_MAX : 8'(q.half_cnt + 8'h01);
    // private timeout counter
    if (zx_pulse) begin
      d.tmo_cnt = tout_reload;
      d.armed = 1'b1;
    end else if (tick_to && q.armed) begin
      if (q.tmo_cnt <= 16'h0001) begin
        d.tmo_cnt = 16'h0000;
        d.armed = 1'b0;
        d.miss_evt = 1'b1;
      end else begin
        d.tmo_cnt = 16'(q.tmo_cnt - 16'h0001);
      end
    end
    // a sign change closes a half cycle
    if (smp_valid) begin
      if (v_hi[7] != q.sign_prev) begin
        if (q.below_all) begin
          d.half_cnt = half_inc;
          d.sag_evt = (half_inc == dip_half_cycles);
        end else begin
          d.half_cnt = 8'h00;
        end
        d.below_all = below;
        d.sign_prev = v_hi[7];
      end else begin
        d.below_all = q.below_all & below;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '{tmo_cnt: TOUT_RST, armed: 1'b1, half_cnt: 8'h00, below_all: 1'b0,
             sign_prev: 1'b0, miss_evt: 1'b0, sag_evt: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign miss_evt = q.miss_evt;
  assign sag_evt = q.sag_evt;

  reload_count_a: assert property (@(posedge core_clk) disable iff (srst)
    zx_pulse |=> q.tmo_cnt == $past(tout_reload) && q.armed)
    else $error("timeout counter not reloaded on crossing");
  miss_at_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    q.miss_evt |-> q.tmo_cnt == 16'h0000 && !q.armed && $past(tick_to))
    else $error("missing crossing fired with counter not at zero");
  sag_count_a: assert property (@(posedge core_clk) disable iff (srst)
    q.sag_evt |-> q.half_cnt == $past(dip_half_cycles) && $past(q.below_all))
    else $error("dip event at wrong half-cycle count");
endmodule
`default_nettype wire

// >>> verilog/lvs_pkg.sv
// shared constants, register map and carrier types of the line voltage supervisor
package lvs_pkg;
  localparam int PH_N = 3;                       // number of line phases
  localparam logic [1:0] PH_NONE = 2'h3; // phase select code meaning no phase
  // register addresses on the serial register port
  localparam logic [7:0] A_MODE = 8'h0B;         // measurement_mode
  localparam logic [7:0] A_TOUT = 8'h12;         // crossing_timeout_reload
  localparam logic [7:0] A_DIP_LVL = 8'h13;      // dip_level
  localparam logic [7:0] A_DIP_CYC = 8'h14;      // dip_half_cycles
  localparam logic [7:0] A_VOLTAGE_PEAK_LEVEL = 8'h15;        // voltage_peak_level
  localparam logic [7:0] A_CURRENT_PEAK_LEVEL = 8'h16;        // current_peak_level
  localparam logic [7:0] A_MASK = 8'h17;         // interrupt mask
  localparam logic [7:0] A_STATUS = 8'h18;       // interrupt status, plain read
  localparam logic [7:0] A_STATUS_CLEAR_ON_READ = 8'h19;      // status_clear_on_read
  localparam logic [7:0] A_PERIOD = 8'h1A;       // line period result
  // reset values
  localparam logic [7:0] MODE_RST = 8'h70;       // all phases enabled, phase a
  localparam logic [15:0] TOUT_RST = 16'hFFFF;
  localparam logic [7:0] DIP_LVL_RST = 8'h00;
  localparam logic [7:0] DIP_CYC_RST = 8'hFF;
  localparam logic [7:0] PEAK_RST = 8'hFF;
  localparam logic [15:0] MASK_RST = 16'h0000;
  // timing, in master clock cycles and nanoseconds
  localparam int TO_DIV = 384;                   // timeout decrement interval
  localparam int PERIOD_LSB_NS = 2400;           // period resolution at reference clock
  localparam int MASTER_REF_NS = 100;            // reference master clock period
  localparam int PER_DIV = PERIOD_LSB_NS / MASTER_REF_NS;
  localparam logic [8:0] TO_LAST = 9'(TO_DIV - 1);
  localparam logic [4:0] PER_LAST = 5'(PER_DIV - 1);
  localparam logic [14:0] PERIOD_MAX = 15'h7FFF;
  localparam logic [7:0] HALF_MAX = 8'hFF;
  // measurement_mode layout
  typedef struct packed {
    logic rsvd;
    logic [2:0] crossing_phase_enable;
    logic [1:0] peak_phase_select;
    logic [1:0] period_phase_select;
  } lvs_mode_t;
  // interrupt status and mask layout
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic cur_peak;
    logic voltage_over_peak_flag;
    logic [2:0] zero_cross;
    logic [2:0] missing_crossing_flag;
    logic [2:0] dip;
    logic rsvd_lo;
  } lvs_status_t;
  // samples and crossing pulses from the signal chain
  typedef struct packed {
    logic valid;
    logic [2:0] zx;
    logic [2:0][15:0] volt;
    logic [2:0][23:0] curr;
  } lvs_samples_t;
  // register access from the serial port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } lvs_reg_req_t;
  // per-phase state
  typedef struct packed {
    logic [15:0] tmo_cnt;
    logic armed;
    logic [7:0] half_cnt;
    logic below_all;
    logic sign_prev;
    logic miss_evt;
    logic sag_evt;
  } lvs_ph_state_t;
  // supervisor state
  typedef struct packed {
    lvs_mode_t mode;
    logic [15:0] tout_reload;
    logic [7:0] dip_level;
    logic [7:0] dip_half;
    logic [7:0] voltage_peak_level;
    logic [7:0] current_peak_level;
    lvs_status_t mask;
    lvs_status_t status;
    logic [14:0] period_cnt;
    logic [14:0] period;
    logic [8:0] presc_to;
    logic [4:0] presc_per;
    logic tick_to;
    logic tick_per;
    logic [15:0] rdata;
    logic irq_n;
  } lvs_state_t;
  // magnitude of a signed high byte, nine bits so that -128 fits
  function automatic logic [8:0] abs_hi(input logic [7:0] b);
    abs_hi = b[7] ? 9'(9'h000 - {b[7], b}) : {1'b0, b};
  endfunction
endpackage

// >>> verilog/lvs_supervisor.sv
// line voltage supervisor: registers, period, peaks, status flags and interrupt
`timescale 1ns/100ps
`default_nettype none
// register port: one-cycle write and read strobes, read data one cycle on
// read data holds until the next read, so the host may pick it up late
// flags are sticky; an event in the cycle of a clear-on-read is kept
// crossing and timeout interrupts also need the phase enable bit
// a disabled phase shows its missing-crossing flag as set on every read
// phase code 3 parks the period capture or the peak checks
// the host keeps the period phase among the enabled phases
// both dividers run free from reset and never resync to crossings
// the interrupt line is registered, so it never glitches
// every top-level output comes straight from the state register
// Contract
// - crossing interrupt needs mask and phase enable
// - private 16-bit timeout decrements every 384 cycles
// - crossing reloads timeout from shared reload register
// - timeout reaching zero sets missing-crossing flag
// - missing-crossing flag interrupts when its mask set; the code also needs the phase enable bit
// - disabled phase reads missing-crossing flag as set
// - 15-bit period on selected phase, per period
// - period counts in steps of 24 cycles
// - dip check on all phases, shared settings
// - dip flagged at programmed half-cycle count
// - dip interrupts only when its mask set
// - dip level versus absolute voltage high byte
// - below when level strictly above sample
// - one phase selected for voltage and current peaks
// - peak levels versus absolute sample high bytes
// - voltage over peak sets flag, masked interrupt
// - current peak when level strictly below sample
// - rising crossing sets phase crossing flag
// - clear-on-read status read clears flags
module lvs_supervisor import lvs_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  input wire lvs_samples_t smp,
  input wire lvs_reg_req_t req,
  output logic [15:0] reg_rdata,
  output logic irq_n
);
  lvs_state_t q, d;            // whole state and its next value
  logic [2:0] miss_evt;        // per-phase missing crossing pulses
  logic [2:0] sag_evt;         // per-phase dip pulses
  lvs_status_t set_v;          // flags raised this cycle
  lvs_status_t view;           // status as software reads it
  lvs_status_t pend;           // flags allowed onto the interrupt
  logic per_valid;             // period phase select names a phase
  logic per_zx;                // rising crossing on period phase
  logic [1:0] psel;            // peak phase
  logic [7:0] v_pk_hi;         // high byte of peak phase voltage
  logic [7:0] i_pk_hi;         // high byte of peak phase current
  logic clr;                   // clear-on-read access this cycle

  // per-phase timeout and dip logic, all sharing one set of settings
  // each phase owns its counters; the settings, the timeout tick and the sample strobe are shared
  generate
    for (genvar p = 0; p < PH_N; p++) begin : g_ph
      lvs_phase u_ph (
        .core_clk(core_clk),
        .srst(srst),
        .tick_to(q.tick_to),
        .smp_valid(smp.valid),
        .zx_pulse(smp.zx[p]),
        .v_hi(smp.volt[p][15:8]),
        .dip_level(q.dip_level),
        .dip_half_cycles(q.dip_half),
        .tout_reload(q.tout_reload),
        .miss_evt(miss_evt[p]),
        .sag_evt(sag_evt[p])
      );
    end
  endgenerate

  // peak phase sample selection
  always_comb begin
    psel = q.mode.peak_phase_select;
    case (psel)
      2'h0: begin
        v_pk_hi = smp.volt[0][15:8];
        i_pk_hi = smp.curr[0][23:16];
      end
      2'h1: begin
        v_pk_hi = smp.volt[1][15:8];
        i_pk_hi = smp.curr[1][23:16];
      end
      2'h2: begin
        v_pk_hi = smp.volt[2][15:8];
        i_pk_hi = smp.curr[2][23:16];
      end
      default: begin
        // no phase: magnitudes of zero never exceed a level
        v_pk_hi = 8'h00;
        i_pk_hi = 8'h00;
      end
    endcase
  end

  // next state
  always_comb begin
    d = q;
    d.tick_to = 1'b0;
    d.tick_per = 1'b0;
    // timeout decrement divider
    if (q.presc_to == TO_LAST) begin
      d.presc_to = 9'h000;
      d.tick_to = 1'b1;
    end else begin
      d.presc_to = 9'(q.presc_to + 9'h001);
    end
    // period resolution divider
    if (q.presc_per == PER_LAST) begin
      d.presc_per = 5'h00;
      d.tick_per = 1'b1;
    end else begin
      d.presc_per = 5'(q.presc_per + 5'h01);
    end
    // period measurement; the host keeps the selected phase enabled
    // phase code 3 parks the measurement; the last result stays readable
    per_valid = q.mode.period_phase_select != PH_NONE;
    per_zx = 1'b0;
    if (per_valid) begin
      per_zx = smp.zx[q.mode.period_phase_select];
    end
    // a capture wins over a tick that lands in the same cycle
    if (per_zx) begin
      d.period = q.period_cnt;
      d.period_cnt = 15'h0000;
    end else if (q.tick_per && q.period_cnt != PERIOD_MAX) begin
      d.period_cnt = 15'(q.period_cnt + 15'h0001);
    end
    // events raised this cycle
    set_v = '0;
    set_v.dip = sag_evt;
    set_v.missing_crossing_flag = miss_evt;
    set_v.zero_cross = smp.zx;
    if (smp.valid) begin
      set_v.voltage_over_peak_flag = abs_hi(v_pk_hi) > {1'b0, q.voltage_peak_level};
      set_v.cur_peak = {1'b0, q.current_peak_level} < abs_hi(i_pk_hi);
    end
    // clear-on-read, with a same-cycle event kept
    clr = req.rd && req.addr == A_STATUS_CLEAR_ON_READ;
    d.status = (clr ? lvs_status_t'('0) : q.status) | set_v;
    // disabled phases show a missing crossing all the time
    view = q.status;
    view.missing_crossing_flag = q.status.missing_crossing_flag
                                 | ~q.mode.crossing_phase_enable;
    // register writes
    // a write lands at the taking edge; a same-cycle read sees the old value
    if (req.wr) begin
      case (req.addr)
        A_MODE: d.mode = lvs_mode_t'(req.wdata[7:0]);
        A_TOUT: d.tout_reload = req.wdata;
        A_DIP_LVL: d.dip_level = req.wdata[7:0];
        A_DIP_CYC: d.dip_half = req.wdata[7:0];
        A_VOLTAGE_PEAK_LEVEL: d.voltage_peak_level = req.wdata[7:0];
        A_CURRENT_PEAK_LEVEL: d.current_peak_level = req.wdata[7:0];
        A_MASK: d.mask = lvs_status_t'(req.wdata);
        default: begin
          // read-only or unmapped: write ignored
        end
      endcase
    end
    // register reads, held until the next read
    if (req.rd) begin
      case (req.addr)
        A_MODE: d.rdata = {8'h00, q.mode};
        A_TOUT: d.rdata = q.tout_reload;
        A_DIP_LVL: d.rdata = {8'h00, q.dip_level};
        A_DIP_CYC: d.rdata = {8'h00, q.dip_half};
        A_VOLTAGE_PEAK_LEVEL: d.rdata = {8'h00, q.voltage_peak_level};
        A_CURRENT_PEAK_LEVEL: d.rdata = {8'h00, q.current_peak_level};
        A_MASK: d.rdata = q.mask;
        A_STATUS: d.rdata = view;
        A_STATUS_CLEAR_ON_READ: d.rdata = view;
        A_PERIOD: d.rdata = {1'b0, q.period};
        default: d.rdata = 16'h0000;
      endcase
    end
    // interrupt: crossing and timeout also need the phase enable
    pend = q.status & q.mask;
    pend.zero_cross = q.status.zero_cross & q.mask.zero_cross
                      & q.mode.crossing_phase_enable;
    pend.missing_crossing_flag = q.status.missing_crossing_flag
                                 & q.mask.missing_crossing_flag
                                 & q.mode.crossing_phase_enable;
    // any pending unmasked flag pulls the line low one cycle later
    d.irq_n = ~(|pend);
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '{mode: lvs_mode_t'(MODE_RST), // all phases enabled
             tout_reload: TOUT_RST,
             dip_level: DIP_LVL_RST,
             dip_half: DIP_CYC_RST,
             voltage_peak_level: PEAK_RST,
             current_peak_level: PEAK_RST,
             mask: lvs_status_t'(MASK_RST), // nothing reaches the line
             status: lvs_status_t'('0), // no flags pending
             period_cnt: 15'h0000,
             period: 15'h0000,
             presc_to: 9'h000, // first timeout tick one interval on
             presc_per: 5'h00,
             tick_to: 1'b0,
             tick_per: 1'b0,
             rdata: 16'h0000,
             irq_n: 1'b1}; // line released
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq_n = q.irq_n;

  // all phases disabled with only crossing masks set keeps the line high
  zx_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    (q.mask.zero_cross != 3'h0 && q.mask.missing_crossing_flag == 3'h0
     && q.mask.dip == 3'h0 && !q.mask.voltage_over_peak_flag && !q.mask.cur_peak
     && q.mode.crossing_phase_enable == 3'h0) |=> irq_n)
    else $error("crossing interrupt not gated by phase enable");
  to_tick_gap_a: assert property (@(posedge core_clk) disable iff (srst)
    q.tick_to |=> !q.tick_to [*8])
    else $error("timeout tick too frequent");
  miss_flag_a: assert property (@(posedge core_clk) disable iff (srst)
    miss_evt != 3'h0 |=> (q.status.missing_crossing_flag & $past(miss_evt)) == $past(miss_evt))
    else $error("missing crossing event lost");
  miss_view_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd && req.addr == A_STATUS && !q.mode.crossing_phase_enable[0]) |=> reg_rdata[4])
    else $error("disabled phase does not read missing crossing");
  period_cap_a: assert property (@(posedge core_clk) disable iff (srst)
    per_zx |=> q.period == $past(q.period_cnt) && q.period_cnt == 15'h0000)
    else $error("period not captured on crossing");
  period_step_a: assert property (@(posedge core_clk) disable iff (srst)
    (!per_zx && q.period_cnt != PERIOD_MAX && !q.tick_per) |=> $stable(q.period_cnt))
    else $error("period counter moved without resolution tick");
  voltage_peak_level_flag_a: assert property (@(posedge core_clk) disable iff (srst)
    (smp.valid && psel != PH_NONE && abs_hi(v_pk_hi) > {1'b0, q.voltage_peak_level})
    |=> q.status.voltage_over_peak_flag)
    else $error("voltage peak not flagged");
  current_peak_level_flag_a: assert property (@(posedge core_clk) disable iff (srst)
    (smp.valid && psel != PH_NONE && abs_hi(i_pk_hi) > {1'b0, q.current_peak_level})
    |=> q.status.cur_peak)
    else $error("current peak not flagged");
  rd_clear_a: assert property (@(posedge core_clk) disable iff (srst)
    (clr && set_v == lvs_status_t'('0)) |=> q.status == lvs_status_t'('0))
    else $error("clear-on-read left flags set");
  dip_irq_a: assert property (@(posedge core_clk) disable iff (srst)
    (q.status.dip[0] && q.mask.dip[0]) |=> !irq_n)
    else $error("unmasked dip did not assert interrupt");

  // every rising crossing is latched into its flag
  zx_flag_a: assert property (@(posedge core_clk) disable iff (srst)
    smp.zx != 3'h0 |=> (q.status.zero_cross & $past(smp.zx)) == $past(smp.zx))
    else $error("crossing flag not set");

  // an enabled, unmasked crossing flag pulls the line low
  zx_irq_a: assert property (@(posedge core_clk) disable iff (srst)
    (q.status.zero_cross & q.mask.zero_cross & q.mode.crossing_phase_enable) != 3'h0
    |=> !irq_n)
    else $error("enabled crossing did not interrupt");

  // an enabled, unmasked missing crossing pulls the line low
  miss_irq_a: assert property (@(posedge core_clk) disable iff (srst)
    (q.status.missing_crossing_flag & q.mask.missing_crossing_flag
     & q.mode.crossing_phase_enable) != 3'h0 |=> !irq_n)
    else $error("missing crossing did not interrupt");

  // every dip pulse is latched into its flag
  dip_flag_a: assert property (@(posedge core_clk) disable iff (srst)
    sag_evt != 3'h0 |=> (q.status.dip & $past(sag_evt)) == $past(sag_evt))
    else $error("dip event lost");

  // no masked flag pending keeps the line high
  irq_idle_a: assert property (@(posedge core_clk) disable iff (srst)
    (q.status & q.mask) == lvs_status_t'('0) |=> irq_n)
    else $error("interrupt without an unmasked flag");

  // an unmasked voltage peak pulls the line low
  voltage_peak_level_irq_a: assert property (@(posedge core_clk) disable iff (srst)
    (q.status.voltage_over_peak_flag && q.mask.voltage_over_peak_flag) |=> !irq_n)
    else $error("voltage peak did not interrupt");

  // a voltage at the level is not a peak
  voltage_peak_level_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
    (smp.valid && abs_hi(v_pk_hi) <= {1'b0, q.voltage_peak_level} && !q.status.voltage_over_peak_flag)
    |=> !q.status.voltage_over_peak_flag)
    else $error("voltage peak flagged at or below level");

  // a current at the level is not a peak
  current_peak_level_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
    (smp.valid && abs_hi(i_pk_hi) <= {1'b0, q.current_peak_level} && !q.status.cur_peak)
    |=> !q.status.cur_peak)
    else $error("current peak flagged at or below level");

  // no peak phase raises no peak flag
  peak_none_a: assert property (@(posedge core_clk) disable iff (srst)
    (psel == PH_NONE && !q.status.cur_peak && !q.status.voltage_over_peak_flag)
    |=> !q.status.cur_peak && !q.status.voltage_over_peak_flag)
    else $error("peak flagged with no phase selected");

  // timeout tick follows the last divider count
  to_tick_rate_a: assert property (@(posedge core_clk) disable iff (srst)
    q.presc_to == TO_LAST |=> q.tick_to)
    else $error("timeout tick missing");

  // period ticks stay apart
  per_tick_gap_a: assert property (@(posedge core_clk) disable iff (srst)
    q.tick_per |=> !q.tick_per [*8])
    else $error("period tick too frequent");

  // one count per period tick
  period_tick_a: assert property (@(posedge core_clk) disable iff (srst)
    (!per_zx && q.tick_per && q.period_cnt != PERIOD_MAX)
    |=> q.period_cnt == 15'($past(q.period_cnt) + 15'h0001))
    else $error("period counter missed a tick");

  // the period counter saturates
  period_sat_a: assert property (@(posedge core_clk) disable iff (srst)
    (!per_zx && q.period_cnt == PERIOD_MAX) |=> q.period_cnt == PERIOD_MAX)
    else $error("period counter wrapped");

  // mode writes land whole
  mode_wr_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.wr && req.addr == A_MODE) |=> q.mode == lvs_mode_t'($past(req.wdata[7:0])))
    else $error("mode write lost");

  // reload writes land whole
  reload_wr_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.wr && req.addr == A_TOUT) |=> q.tout_reload == $past(req.wdata))
    else $error("reload write lost");

  // dip level writes take the low byte
  dip_lvl_wr_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.wr && req.addr == A_DIP_LVL) |=> q.dip_level == $past(req.wdata[7:0]))
    else $error("dip level write lost");
endmodule
`default_nettype wire
